// *** rtl/vfs_consts.vh ***
`ifndef VFS_CONSTS_VH
`define VFS_CONSTS_VH

// Parameter bus offsets (5-bit byte addresses)
`define VFS_OFF_IN_W       5'h00
`define VFS_OFF_IN_H       5'h04
`define VFS_OFF_OUT_W      5'h08
`define VFS_OFF_OUT_H      5'h0c
`define VFS_OFF_VSF        5'h10
`define VFS_OFF_HSF        5'h14
`define VFS_OFF_UPD        5'h18

// Commit request bit position and reset value
`define VFS_UPD_BIT        0
`define VFS_UPD_RST        1'b0

// Smallest legal size register content
`define VFS_MIN_DIM        31

// Video formats
`define VFS_FMT_MONO       0
`define VFS_FMT_422        1

// Kernels
`define VFS_KERN_NEAREST   0
`define VFS_KERN_BILINEAR  1
`define VFS_KERN_BICUBIC   2
`define VFS_KERN_LANCZOS   3

// Line buffer rows kept in flight and their index width
`define VFS_LINES          4
`define VFS_LINE_BITS      2

// Position accumulator width
`define VFS_ACC_W          48

`endif

// *** rtl/vfs_line_mem.v ***
`timescale 1ns/10ps
`default_nettype none

module vfs_line_mem #(
  parameter DW = 24,
  parameter AW = 12
) (
  input  wire          sys_clk,
  input  wire          srst,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port, one cycle of latency
  always @(posedge sys_clk) begin
    if (srst) begin
      rdata <= {DW{1'b0}};
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// *** rtl/vfs_param_regs.v ***
`timescale 1ns/10ps
`default_nettype none
`include "vfs_consts.vh"

module vfs_param_regs #(
  parameter [31:0] IN_W_RST  = 32'h0000_02cf,
  parameter [31:0] IN_H_RST  = 32'h0000_023f,
  parameter [31:0] OUT_W_RST = 32'h0000_04ff,
  parameter [31:0] OUT_H_RST = 32'h0000_02cf,
  parameter [31:0] VSF_RST   = 32'h0000_0000,
  parameter [31:0] HSF_RST   = 32'h0000_0000
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        pwrite,
  input  wire [4:0]  paddr,
  input  wire [31:0] pwdat,
  output reg  [31:0] prdat,
  input  wire        commit_done,
  output reg  [31:0] input_width_minus_one,
  output reg  [31:0] input_height_minus_one,
  output reg  [31:0] output_width_minus_one,
  output reg  [31:0] output_height_minus_one,
  output reg  [31:0] vertical_scale_factor,
  output reg  [31:0] horizontal_scale_factor,
  output reg         commit_request
);

  wire wr_ok = pwrite & ~commit_request;

  reg [31:0] rd_d;

  always @* begin
    case (paddr)
      `VFS_OFF_IN_W:  rd_d = input_width_minus_one;
      `VFS_OFF_IN_H:  rd_d = input_height_minus_one;
      `VFS_OFF_OUT_W: rd_d = output_width_minus_one;
      `VFS_OFF_OUT_H: rd_d = output_height_minus_one;
      `VFS_OFF_VSF:   rd_d = vertical_scale_factor;
      `VFS_OFF_HSF:   rd_d = horizontal_scale_factor;
      `VFS_OFF_UPD:   rd_d = {31'h0000_0000, commit_request};
      default:        rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      input_width_minus_one   <= IN_W_RST;
      input_height_minus_one  <= IN_H_RST;
      output_width_minus_one  <= OUT_W_RST;
      output_height_minus_one <= OUT_H_RST;
      vertical_scale_factor   <= VSF_RST;
      horizontal_scale_factor <= HSF_RST;
      commit_request          <= `VFS_UPD_RST;
      prdat                   <= 32'h0000_0000;
    end else if (ce) begin
      prdat <= rd_d;
      if (commit_done) begin
        commit_request <= 1'b0;
      end
      if (wr_ok) begin
        case (paddr)
          `VFS_OFF_IN_W:  input_width_minus_one   <= pwdat;
          `VFS_OFF_IN_H:  input_height_minus_one  <= pwdat;
          `VFS_OFF_OUT_W: output_width_minus_one  <= pwdat;
          `VFS_OFF_OUT_H: output_height_minus_one <= pwdat;
          `VFS_OFF_VSF:   vertical_scale_factor   <= pwdat;
          `VFS_OFF_HSF:   horizontal_scale_factor <= pwdat;
          `VFS_OFF_UPD:   commit_request          <= pwdat[`VFS_UPD_BIT];
          default:        commit_request          <= commit_request;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/vfs_scaler.v ***
// Notes on behaviour
// - Input width register holds width minus one
// - Input height register holds rows minus one
// - Output columns per line are register plus one
// - Output rows per frame are register plus one
// - Size registers reset to maximum minus one
// - Maximum sizes used until first commit
// - Vertical factor is input over output height
// - Horizontal factor is input over output width
// - Fraction width is max of two logs
// - Nearest/bilinear fraction raised to coefficient width
// - Commit request resets zero, host sets one
// - Register writes ignored while commit pending
// - Pending commit loads working set at frame start
// - Commit request cleared after loading
// - Vertical filtering first, then horizontal
// - Line buffer feeds vertical filter column-wise
// - Vertical results feed horizontal; output rounded
// - 4:2:2 chroma averaged into 4:4:4 pixels
// - Nearest, bilinear kernels fixed; bicubic, Lanczos use phase-quantized bilinear
// - Parameter bus runs on pixel clock
// - Unwritten registers carry old values over
// - Read data follow previous cycle address
`timescale 1ns/10ps
`default_nettype none
`include "vfs_consts.vh"

module vfs_scaler #(
  parameter MAX_IN_W  = 720,
  parameter MAX_IN_H  = 576,
  parameter MAX_OUT_W = 1280,
  parameter MAX_OUT_H = 720,
  parameter FORMAT    = `VFS_FMT_422,
  parameter KERNEL    = `VFS_KERN_LANCZOS,
  parameter V_PHASES  = 64,
  parameter H_PHASES  = 64,
  parameter PIX_W     = 8,
  parameter COEF_W    = 9
) (
  input  wire                                        sys_clk,
  input  wire                                        srst,
  input  wire                                        ce,
  input  wire [((FORMAT==`VFS_FMT_422)?2:1)*PIX_W-1:0] din,
  input  wire                                        dvalid_in,
  input  wire                                        frmsync_in,
  output wire                                        ready,
  input  wire                                        dout_enable,
  output reg                                         dvalid_out,
  output reg                                         frmsync_out,
  output reg  [((FORMAT==`VFS_FMT_422)?2:1)*PIX_W-1:0] dout,
  output reg  [15:0]                                 fwidth_out,
  output reg  [15:0]                                 fheight_out,
  input  wire                                        pwrite,
  input  wire [4:0]                                  paddr,
  input  wire [31:0]                                 pwdat,
  output wire [31:0]                                 prdat
);

  function integer clog2;
    input integer v;
    integer i;
    begin
      clog2 = 0;
      for (i = v - 1; i > 0; i = i >> 1) begin
        clog2 = clog2 + 1;
      end
    end
  endfunction

  localparam NCH    = (FORMAT == `VFS_FMT_422) ? 3 : 1;
  localparam DIN_W  = ((FORMAT == `VFS_FMT_422) ? 2 : 1) * PIX_W;
  localparam MW     = NCH * PIX_W;
  localparam CW     = clog2(MAX_IN_W);
  localparam AW     = CW + `VFS_LINE_BITS;
  localparam ACW    = `VFS_ACC_W;
  localparam V_PB   = clog2(V_PHASES);
  localparam H_PB   = clog2(H_PHASES);
  localparam VF0    = (clog2(MAX_OUT_H) > V_PB) ? clog2(MAX_OUT_H) : V_PB;
  localparam HF0    = (clog2(MAX_OUT_W) > H_PB) ? clog2(MAX_OUT_W) : H_PB;
  localparam SIMPLE = (KERNEL == `VFS_KERN_NEAREST) || (KERNEL == `VFS_KERN_BILINEAR);
  localparam VF     = (SIMPLE && VF0 < COEF_W) ? COEF_W : VF0;
  localparam HF     = (SIMPLE && HF0 < COEF_W) ? COEF_W : HF0;
  localparam SW     = PIX_W + COEF_W + 3;
  localparam HW     = SW + COEF_W + 2;
  localparam [31:0] IW_M1 = MAX_IN_W - 1;
  localparam [31:0] IH_M1 = MAX_IN_H - 1;
  localparam [31:0] OW_M1 = MAX_OUT_W - 1;
  localparam [31:0] OH_M1 = MAX_OUT_H - 1;
  localparam [31:0] VSF_RST = (MAX_IN_H << VF) / MAX_OUT_H;
  localparam [31:0] HSF_RST = (MAX_IN_W << HF) / MAX_OUT_W;
  localparam [COEF_W-1:0] V_MASK = (V_PB >= COEF_W) ? {COEF_W{1'b1}} : ({COEF_W{1'b1}} << (COEF_W - V_PB));
  localparam [COEF_W-1:0] H_MASK = (H_PB >= COEF_W) ? {COEF_W{1'b1}} : ({COEF_W{1'b1}} << (COEF_W - H_PB));
  localparam [1:0] O_IDLE  = 2'd0;
  localparam [1:0] O_FETCH = 2'd1;
  localparam [1:0] O_CALC  = 2'd2;
  localparam [1:0] O_EMIT  = 2'd3;

  // Kernel weight of the far tap, COEF_W fraction bits
  function [COEF_W:0] kern;
    input [COEF_W-1:0] t;
    input [COEF_W-1:0] mask;
    begin
      case (KERNEL)
        `VFS_KERN_NEAREST:  kern = t[COEF_W-1] ? {1'b1, {COEF_W{1'b0}}} : {(COEF_W+1){1'b0}};
        `VFS_KERN_BILINEAR: kern = {1'b0, t};
        default:            kern = {1'b0, t & mask};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Parameter registers and working set

  wire [31:0] reg_iw;
  wire [31:0] reg_ih;
  wire [31:0] reg_ow;
  wire [31:0] reg_oh;
  wire [31:0] reg_vsf;
  wire [31:0] reg_hsf;
  wire        commit_req;
  reg         commit_done_q;

  // Same clock as the pixel side
  vfs_param_regs #(
    .IN_W_RST  (MAX_IN_W - 1),
    .IN_H_RST  (MAX_IN_H - 1),
    .OUT_W_RST (MAX_OUT_W - 1),
    .OUT_H_RST (MAX_OUT_H - 1),
    .VSF_RST   (VSF_RST),
    .HSF_RST   (HSF_RST)
  ) u_regs (
    .sys_clk                 (sys_clk),
    .srst                    (srst),
    .ce                      (ce),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdat                   (pwdat),
    .prdat                   (prdat),
    .commit_done             (commit_done_q),
    .input_width_minus_one   (reg_iw),
    .input_height_minus_one  (reg_ih),
    .output_width_minus_one  (reg_ow),
    .output_height_minus_one (reg_oh),
    .vertical_scale_factor   (reg_vsf),
    .horizontal_scale_factor (reg_hsf),
    .commit_request          (commit_req)
  );

  reg [15:0] wiw_q;
  reg [15:0] wih_q;
  reg [15:0] wow_q;
  reg [15:0] woh_q;
  reg [31:0] wvsf_q;
  reg [31:0] whsf_q;

  ////////////////////////////////////////////////////////////////////////////
  // Input side: 4:2:2 to 4:4:4 and line buffer writes

  reg              in_act_q;
  reg              flush_q;
  reg [15:0]       in_col_q;
  reg [15:0]       in_row_q;
  reg [PIX_W-1:0]  hold_y_q;
  reg [PIX_W-1:0]  hold_c_q;
  reg [PIX_W-1:0]  prev_c_q;
  reg [1:0]        ost_q;
  wire [15:0]      out_r;

  wire             out_idle = (ost_q == O_IDLE);
  wire [16:0]      row_lim  = {1'b0, out_r} + 17'd`VFS_LINES;
  // Once the output frame is done, the remaining input rows need no buffer room
  assign ready = ~flush_q & (in_act_q ? (out_idle | ({1'b0, in_row_q} < row_lim)) : out_idle);

  wire             accept = dvalid_in & ready;
  wire             sof    = accept & frmsync_in & ~in_act_q;
  wire             pix    = accept & in_act_q;
  wire [PIX_W-1:0] y_in   = din[DIN_W-1 -: PIX_W];
  wire [PIX_W-1:0] c_in   = din[PIX_W-1:0];
  wire [PIX_W:0]   c_sum  = {1'b0, prev_c_q} + {1'b0, c_in};
  wire [PIX_W-1:0] c_avg  = (in_col_q == 16'd1) ? c_in : c_sum[PIX_W:1];

  // Pixels are written one behind; the last of a line in a flush cycle
  wire             mem_we   = flush_q | (pix & (in_col_q != 16'd0));
  wire [15:0]      wcol     = flush_q ? wiw_q : (in_col_q - 16'd1);
  wire [PIX_W-1:0] w_other  = flush_q ? prev_c_q : c_avg;
  wire [AW-1:0]    mem_wa   = {in_row_q[`VFS_LINE_BITS-1:0], wcol[CW-1:0]};
  wire [MW-1:0]    mem_wd;

  generate
    if (NCH == 3) begin : g_pack422
      assign mem_wd = wcol[0] ? {hold_y_q, w_other, hold_c_q} : {hold_y_q, hold_c_q, w_other};
    end else begin : g_packmono
      assign mem_wd = hold_y_q;
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (srst) begin
      in_act_q      <= 1'b0;
      flush_q       <= 1'b0;
      in_col_q      <= 16'h0000;
      in_row_q      <= 16'h0000;
      hold_y_q      <= {PIX_W{1'b0}};
      hold_c_q      <= {PIX_W{1'b0}};
      prev_c_q      <= {PIX_W{1'b0}};
      commit_done_q <= 1'b0;
      wiw_q         <= IW_M1[15:0];
      wih_q         <= IH_M1[15:0];
      wow_q         <= OW_M1[15:0];
      woh_q         <= OH_M1[15:0];
      wvsf_q        <= VSF_RST;
      whsf_q        <= HSF_RST;
    end else if (ce) begin
      commit_done_q <= 1'b0;
      if (sof) begin
        in_act_q <= 1'b1;
        in_col_q <= 16'h0001;
        in_row_q <= 16'h0000;
        hold_y_q <= y_in;
        hold_c_q <= c_in;
        if (commit_req) begin
          wiw_q         <= reg_iw[15:0];
          wih_q         <= reg_ih[15:0];
          wow_q         <= reg_ow[15:0];
          woh_q         <= reg_oh[15:0];
          wvsf_q        <= reg_vsf;
          whsf_q        <= reg_hsf;
          commit_done_q <= 1'b1;
        end
      end else if (pix) begin
        hold_y_q <= y_in;
        hold_c_q <= c_in;
        prev_c_q <= hold_c_q;
        if (in_col_q == wiw_q) begin
          flush_q  <= 1'b1;
          in_col_q <= 16'h0000;
        end else begin
          in_col_q <= in_col_q + 16'd1;
        end
      end
      if (flush_q) begin
        flush_q  <= 1'b0;
        in_row_q <= in_row_q + 16'd1;
        if (in_row_q == wih_q) begin
          in_act_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output side: fetch 2x2 neighbourhood, filter, emit

  reg [15:0]     ox_q;
  reg [15:0]     oy_q;
  reg [ACW-1:0]  hacc_q;
  reg [ACW-1:0]  vacc_q;
  reg [2:0]      step_q;
  reg [1:0]      idx_q;
  reg            issued_q;
  reg [MW-1:0]   p_q [0:3];
  reg [MW-1:0]   res_q;
  wire [MW-1:0]  rd_data;
  wire [MW-1:0]  filt;

  wire [15:0] vr    = vacc_q[VF +: 16];
  wire [15:0] hc    = hacc_q[HF +: 16];
  assign out_r      = (vr > wih_q) ? wih_q : vr;
  wire [15:0] out_r1 = (out_r >= wih_q) ? wih_q : out_r + 16'd1;
  wire [15:0] out_c  = (hc > wiw_q) ? wiw_q : hc;
  wire [15:0] out_c1 = (out_c >= wiw_q) ? wiw_q : out_c + 16'd1;
  // Rows fully written so far; all of them once input has left the frame
  wire        rows_ok = ~in_act_q | (in_row_q > out_r1);

  wire [15:0]   rrow   = step_q[0] ? out_r1 : out_r;
  wire [15:0]   rcol   = step_q[1] ? out_c1 : out_c;
  wire [AW-1:0] mem_ra = {rrow[`VFS_LINE_BITS-1:0], rcol[CW-1:0]};

  vfs_line_mem #(
    .DW (MW),
    .AW (AW)
  ) u_mem (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (mem_wa),
    .wdata   (mem_wd),
    .raddr   (mem_ra),
    .rdata   (rd_data)
  );

  wire [VF+COEF_W-1:0] tv_x = {vacc_q[VF-1:0], {COEF_W{1'b0}}} >> VF;
  wire [HF+COEF_W-1:0] th_x = {hacc_q[HF-1:0], {COEF_W{1'b0}}} >> HF;
  wire [COEF_W:0]      wv   = kern(tv_x[COEF_W-1:0], V_MASK);
  wire [COEF_W:0]      wh   = kern(th_x[COEF_W-1:0], H_MASK);

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      wire [PIX_W-1:0]     a00 = p_q[0][ch*PIX_W +: PIX_W];
      wire [PIX_W-1:0]     a10 = p_q[1][ch*PIX_W +: PIX_W];
      wire [PIX_W-1:0]     a01 = p_q[2][ch*PIX_W +: PIX_W];
      wire [PIX_W-1:0]     a11 = p_q[3][ch*PIX_W +: PIX_W];
      wire signed [SW-1:0] v0  = $signed({2'b00, a00, {COEF_W{1'b0}}})
                                 + ($signed({1'b0, a10}) - $signed({1'b0, a00})) * $signed({1'b0, wv});
      wire signed [SW-1:0] v1  = $signed({2'b00, a01, {COEF_W{1'b0}}})
                                 + ($signed({1'b0, a11}) - $signed({1'b0, a01})) * $signed({1'b0, wv});
      wire signed [HW-1:0] v0x = {{(COEF_W+2){v0[SW-1]}}, v0};
      wire signed [HW-1:0] v1x = {{(COEF_W+2){v1[SW-1]}}, v1};
      wire signed [HW-1:0] h   = (v0x <<< COEF_W) + (v1x - v0x) * $signed({1'b0, wh});
      wire signed [HW-1:0] hr  = h + $signed({{(HW-2*COEF_W){1'b0}}, 1'b1, {(2*COEF_W-1){1'b0}}});
      wire signed [HW-1:0] hs  = hr >>> (2*COEF_W);
      assign filt[ch*PIX_W +: PIX_W] = hs[HW-1] ? {PIX_W{1'b0}} :
                                       (|hs[HW-2:PIX_W]) ? {PIX_W{1'b1}} : hs[PIX_W-1:0];
    end
  endgenerate

  wire [DIN_W-1:0] out_pix;
  generate
    if (NCH == 3) begin : g_out422
      assign out_pix = {res_q[3*PIX_W-1 -: PIX_W], ox_q[0] ? res_q[PIX_W-1:0] : res_q[2*PIX_W-1 -: PIX_W]};
    end else begin : g_outmono
      assign out_pix = res_q;
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (srst) begin
      ost_q       <= O_IDLE;
      ox_q        <= 16'h0000;
      oy_q        <= 16'h0000;
      hacc_q      <= {ACW{1'b0}};
      vacc_q      <= {ACW{1'b0}};
      step_q      <= 3'd0;
      idx_q       <= 2'd0;
      issued_q    <= 1'b0;
      p_q[0]      <= {MW{1'b0}};
      p_q[1]      <= {MW{1'b0}};
      p_q[2]      <= {MW{1'b0}};
      p_q[3]      <= {MW{1'b0}};
      res_q       <= {MW{1'b0}};
      dvalid_out  <= 1'b0;
      frmsync_out <= 1'b0;
      dout        <= {DIN_W{1'b0}};
      fwidth_out  <= 16'h0000;
      fheight_out <= 16'h0000;
    end else if (ce) begin
      fwidth_out  <= wow_q + 16'd1;
      fheight_out <= woh_q + 16'd1;
      dvalid_out  <= 1'b0;
      frmsync_out <= 1'b0;
      issued_q    <= 1'b0;
      if (issued_q) begin
        p_q[idx_q] <= rd_data;
      end
      case (ost_q)
        O_IDLE: begin
          if (sof) begin
            ost_q  <= O_FETCH;
            ox_q   <= 16'h0000;
            oy_q   <= 16'h0000;
            hacc_q <= {ACW{1'b0}};
            vacc_q <= {ACW{1'b0}};
            step_q <= 3'd0;
          end
        end
        O_FETCH: begin
          if (step_q == 3'd4) begin
            ost_q <= O_CALC;
          end else if (step_q != 3'd0 || rows_ok) begin
            issued_q <= 1'b1;
            idx_q    <= step_q[1:0];
            step_q   <= step_q + 3'd1;
          end
        end
        O_CALC: begin
          res_q <= filt;
          ost_q <= O_EMIT;
        end
        O_EMIT: begin
          if (dout_enable) begin
            dout        <= out_pix;
            dvalid_out  <= 1'b1;
            frmsync_out <= (ox_q == 16'h0000) && (oy_q == 16'h0000);
            step_q      <= 3'd0;
            ost_q       <= O_FETCH;
            if (ox_q == wow_q) begin
              ox_q   <= 16'h0000;
              hacc_q <= {ACW{1'b0}};
              if (oy_q == woh_q) begin
                ost_q <= O_IDLE;
              end else begin
                oy_q   <= oy_q + 16'd1;
                vacc_q <= vacc_q + {{(ACW-32){1'b0}}, wvsf_q};
              end
            end else begin
              ox_q   <= ox_q + 16'd1;
              hacc_q <= hacc_q + {{(ACW-32){1'b0}}, whsf_q};
            end
          end
        end
        default: begin
          ost_q <= O_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic we; logic [4:0] a; logic [31:0] d; logic [31:0] e;} vfs_row_t;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        pwrite = 1'b0;
  logic [4:0]  paddr = 5'h00;
  logic [31:0] pwdat = 32'h0;
  logic        go = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] w = 16'h0028;
  logic [15:0] h = 16'h0024;
  wire  [15:0] din;
  wire  [15:0] dout;
  wire  [15:0] fwidth_out;
  wire  [15:0] fheight_out;
  wire  [31:0] prdat;
  wire         dvalid_in, frmsync_in, ready, dout_enable, dvalid_out, frmsync_out;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          pix_n = 0;
  int          bad_n = 0;
  int          sof_n = 0;
  // Reset contents, unmapped place, then writes that stay uncommitted
  vfs_row_t    rows [15] = '{'{1'b0, 5'h00, 32'h0, 32'h27}, '{1'b0, 5'h04, 32'h0, 32'h23},
    '{1'b0, 5'h08, 32'h0, 32'h27}, '{1'b0, 5'h0c, 32'h0, 32'h23}, '{1'b0, 5'h10, 32'h0, 32'h40},
    '{1'b0, 5'h14, 32'h0, 32'h40}, '{1'b0, 5'h18, 32'h0, 32'h0}, '{1'b1, 5'h1c, 32'h5, 32'h0},
    '{1'b1, 5'h00, 32'h21, 32'h21}, '{1'b1, 5'h04, 32'h1f, 32'h1f}, '{1'b1, 5'h08, 32'h1f, 32'h1f},
    '{1'b1, 5'h0c, 32'h21, 32'h21}, '{1'b1, 5'h10, 32'h3c, 32'h3c}, '{1'b1, 5'h14, 32'h44, 32'h44},
    '{1'b0, 5'h1c, 32'h0, 32'h0}};
  vfs_scaler #(.MAX_IN_W(40), .MAX_IN_H(36), .MAX_OUT_W(40), .MAX_OUT_H(36)) dut_u (.sys_clk(sys_clk),
    .srst(srst), .ce(1'b1), .din(din), .dvalid_in(dvalid_in), .frmsync_in(frmsync_in), .ready(ready),
    .dout_enable(dout_enable), .dvalid_out(dvalid_out), .frmsync_out(frmsync_out), .dout(dout),
    .fwidth_out(fwidth_out), .fheight_out(fheight_out), .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat),
    .prdat(prdat));
  vfs_src src_u (.sys_clk(sys_clk), .srst(srst), .ready(ready), .go(go), .stall(stall), .w(w), .h(h),
    .din(din), .dvalid_in(dvalid_in), .frmsync_in(frmsync_in), .dout_enable(dout_enable), .busy());
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (frmsync_out === 1'b1)
      sof_n <= sof_n + 1;
    if (dvalid_out === 1'b1) begin
      pix_n <= pix_n + 1;
      if (dout !== (pix_n[0] ? 16'h5a7e : 16'h5a3c))
        bad_n <= bad_n + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_row(input vfs_row_t r);
    @(posedge sys_clk);
    if (r.we) begin
      pwrite <= 1'b1;
      paddr <= r.a;
      pwdat <= r.d;
      @(posedge sys_clk);
      pwrite <= 1'b0;
    end
    paddr <= r.a;
    @(posedge sys_clk);
    #1;
    check("prdat", prdat, r.e);
  endtask
  task automatic frame(input logic [15:0] fw, fh, ow, oh, input int n);
    int base;
    int k;
    base = pix_n;
    @(posedge sys_clk);
    w <= fw;
    h <= fh;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (k = 0; k < 60000 && pix_n - base < n; k++)
      @(posedge sys_clk);
    repeat (100) @(posedge sys_clk);
    check("pixel_count", pix_n - base, n);
    check("fwidth_out", fwidth_out, ow);
    check("fheight_out", fheight_out, oh);
  endtask
  task automatic complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (rows[i])
      reg_row(rows[i]);
    frame(16'h0028, 16'h0024, 16'h0028, 16'h0024, 1440);
    reg_row('{1'b1, 5'h18, 32'h1, 32'h1});
    reg_row('{1'b1, 5'h08, 32'h63, 32'h1f});
    stall <= 1'b1;
    frame(16'h0022, 16'h0020, 16'h0020, 16'h0022, 1088);
    reg_row('{1'b0, 5'h18, 32'h0, 32'h0});
    reg_row('{1'b0, 5'h00, 32'h0, 32'h21});
    check("bad_pixels", bad_n, 0);
    check("frame_starts", sof_n, 2);
    complete_run;
  end
endmodule
`default_nettype wire

// *** tb/vfs_scaler_chk_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module vfs_scaler_chk #(
  parameter MAX_OUT_W = 1280
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        dvalid_in,
  input wire logic        frmsync_in,
  input wire logic        ready,
  input wire logic        dout_enable,
  input wire logic        dvalid_out,
  input wire logic        frmsync_out,
  input wire logic [15:0] dout,
  input wire logic [15:0] fwidth_out,
  input wire logic [15:0] fheight_out,
  input wire logic        pwrite,
  input wire logic [4:0]  paddr,
  input wire logic [31:0] pwdat,
  input wire logic [31:0] prdat
);
  logic        pend_q;
  logic        acc_q;
  logic [31:0] shadow_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Commit tracking and a copy of the output width register
  always @(posedge sys_clk) begin
    if (srst) begin
      pend_q <= 1'b0;
      acc_q <= 1'b0;
      shadow_q <= 32'(MAX_OUT_W - 1);
    end else begin
      acc_q <= pend_q && frmsync_in && dvalid_in && ready && ce;
      if (acc_q)
        pend_q <= 1'b0;
      else if (!pend_q && pwrite && paddr == 5'h18 && pwdat[0])
        pend_q <= 1'b1;
      if (!pend_q && pwrite && paddr == 5'h08)
        shadow_q <= pwdat;
    end
  end
  ////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !dvalid_out && !frmsync_out && prdat == 32'h0)
    else $error("outputs active after reset");
  chk_sync_has_valid: assert property (frmsync_out |-> dvalid_out)
    else $error("frame start without valid pixel");
  chk_unmapped_zero: assert property ((paddr > 5'h18 || paddr[1:0] != 2'b00) |=> prdat == 32'h0)
    else $error("unmapped address read nonzero");
  chk_outw_shadow: assert property (paddr == 5'h08 |=> prdat == $past(shadow_q))
    else $error("output width register content wrong");
  chk_commit_read: assert property (paddr == 5'h18 |=> prdat == {31'h0, $past(pend_q)})
    else $error("commit request bit wrong");
  chk_size_stable: assert property (!pend_q && !$past(srst) && !$past(srst, 2) |=> $stable(fwidth_out) && $stable(fheight_out))
    else $error("frame size changed without commit");
  chk_pixel_spacing: assert property (dvalid_out |=> !dvalid_out [*6])
    else $error("output pixels too close");
  chk_stall_hold: assert property (!dout_enable |=> !dvalid_out)
    else $error("pixel emitted while sink stalls");
  chk_dout_hold: assert property (!dvalid_out |-> $stable(dout))
    else $error("output pixel changed without valid");
  cov_frame: cover property (frmsync_out);
  cov_commit: cover property (acc_q);
  cov_stall: cover property (!dout_enable && $past(dvalid_out));
endmodule
bind vfs_scaler vfs_scaler_chk #(.MAX_OUT_W(MAX_OUT_W)) chk_u (.sys_clk(sys_clk), .srst(srst), .ce(ce),
  .dvalid_in(dvalid_in), .frmsync_in(frmsync_in), .ready(ready), .dout_enable(dout_enable),
  .dvalid_out(dvalid_out), .frmsync_out(frmsync_out), .dout(dout), .fwidth_out(fwidth_out),
  .fheight_out(fheight_out), .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat), .prdat(prdat));
`default_nettype wire

// *** tb/vfs_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module vfs_src (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        ready,
  input  wire logic        go,
  input  wire logic        stall,
  input  wire logic [15:0] w,
  input  wire logic [15:0] h,
  output wire logic [15:0] din,
  output logic             dvalid_in,
  output logic             frmsync_in,
  output logic             dout_enable,
  output logic             busy
);
  logic [15:0] col;
  logic [15:0] row;
  logic [3:0]  tick;
  // Flat planes, Cb on even and Cr on odd columns; idle bus inverted
  assign din = dvalid_in ? (col[0] ? 16'h5a7e : 16'h5a3c) : 16'ha5c3;
  always @(posedge sys_clk) begin
    if (srst) begin
      tick <= 4'h0;
      busy <= 1'b0;
      dvalid_in <= 1'b0;
      frmsync_in <= 1'b0;
      dout_enable <= 1'b1;
    end else begin
      tick <= tick + 4'h1;
      dout_enable <= !(stall && tick[3]);
      if (go && !busy) begin
        busy <= 1'b1;
        dvalid_in <= 1'b1;
        frmsync_in <= 1'b1;
        col <= 16'h0;
        row <= 16'h0;
      end else if (dvalid_in && ready) begin
        frmsync_in <= 1'b0;
        if (col == w - 16'h1) begin
          col <= 16'h0;
          row <= row + 16'h1;
          if (row == h - 16'h1) begin
            dvalid_in <= 1'b0;
            busy <= 1'b0;
          end
        end else
          col <= col + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire
